/* File: logic/dthri_host.sv */
// Host end: runs reset and burst setup, then sends digits and collects received ones.
// Assumes the device shares sys_clk; one access takes ACC_CYCLES cycles of strobe.
`timescale 1ns/1ps
module dthri_host
    import dthri_pkg::*;
#(
    parameter int unsigned ACC_CYCLES = 4
) (
    // Clock and reset
    input  wire logic  sys_clk,
    input  wire logic  srst,
    // Host port
    dthri_if.host      port,
    // User side
    input  wire logic  strobeStyle,
    input  wire logic  sendValid,
    input  wire logic [3:0] sendCode,
    output logic       sendReady,
    output logic       recvValid,
    output logic [3:0] recvCode,
    output logic       initDone
);
    typedef enum {S_RST0, S_RST1, S_RST2, S_RST3, S_RST4, S_RST5, S_CTLA, S_CTLB,
                  S_IDLE, S_SEND, S_POLL, S_RXRD} dthri_state_e;
    dthri_state_e state;
    logic [7:0] accCnt;
    logic       accRead;
    logic       accSel;
    logic [3:0] accData;
    logic       txFree;
    logic       irqS1;
    logic       irqS2;
    logic       accEnd;
    logic       accOn;

    // Access shape for each state
    always_comb begin
        accRead = 1'b1;
        accSel  = 1'b1;
        accData = NIB_ZERO;
        case (state)
            S_RST0, S_RST5, S_POLL: accRead = 1'b1;
            S_RST1, S_RST2, S_RST4: begin
                accRead = 1'b0;
                accData = NIB_ZERO;
            end
            S_RST3: begin
                accRead = 1'b0;
                accData = CTL_RESET;
            end
            S_CTLA: begin
                accRead = 1'b0;
                accData = CTL_A_INIT;
            end
            S_CTLB: begin
                accRead = 1'b0;
                accData = CTL_B_INIT;
            end
            S_SEND: begin
                accRead = 1'b0;
                accSel  = 1'b0;
                accData = sendCode;
            end
            S_RXRD: accSel = 1'b0;
            default: accRead = 1'b1;
        endcase
    end

    // Last count of each access is a gap with select and strobes released
    assign accEnd = (accCnt == 8'(ACC_CYCLES));
    assign accOn  = (state != S_IDLE) && !accEnd;

    // Pins; the gap lets the device see every access as a fresh edge
    assign port.busStyleStrobe     = strobeStyle;
    assign port.csN                = !accOn;
    assign port.registerSelectLine = accSel;
    assign port.rwLevel            = accRead;
    assign port.rdStrobeN          = !(accRead && accOn);
    assign port.wrStrobeN          = !(!accRead && accOn);
    assign port.dataToDev          = accData;
    // A pending interrupt takes the next slot, so ready waits for it
    assign sendReady               = initDone && txFree && irqS2 && (state == S_IDLE);

    // Interrupt pin arrives asynchronously as far as the host knows
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irqS1 <= 1'b1;
            irqS2 <= 1'b1;
        end else begin
            irqS1 <= port.irqN;
            irqS2 <= irqS1;
        end
    end

    // Sequencer; each access holds strobes for ACC_CYCLES cycles
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state      <= S_RST0;
            accCnt     <= 8'h0;
            txFree     <= 1'b1;
            initDone   <= 1'b0;
            recvValid  <= 1'b0;
            recvCode   <= NIB_ZERO;
        end else begin
            recvValid <= 1'b0;
            if (state == S_IDLE) begin
                accCnt <= 8'h0;
                if (!irqS2) begin
                    state <= S_POLL;
                end else if (sendValid && txFree && initDone) begin
                    state <= S_SEND;
                end
            end else if (!accEnd) begin
                accCnt <= accCnt + 8'h1;
            end else begin
                accCnt <= 8'h0;
                case (state)
                    S_RST0: state <= S_RST1;
                    S_RST1: state <= S_RST2;
                    S_RST2: state <= S_RST3;
                    S_RST3: state <= S_RST4;
                    S_RST4: state <= S_RST5;
                    S_RST5: state <= S_CTLA;
                    S_CTLA: state <= S_CTLB;
                    S_CTLB: begin
                        state    <= S_IDLE;
                        initDone <= 1'b1;
                    end
                    S_SEND: begin
                        txFree <= 1'b0;
                        state  <= S_IDLE;
                    end
                    S_POLL: begin
                        if (port.dataFromDev[ST_TXRDY]) begin
                            txFree <= 1'b1;
                        end
                        // Receive read comes before the next digit write
                        state <= port.dataFromDev[ST_RXFUL] ? S_RXRD : S_IDLE;
                    end
                    S_RXRD: begin
                        recvValid <= 1'b1;
                        recvCode  <= port.dataFromDev;
                        state     <= S_IDLE;
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: logic/dthri_pkg.sv */
// Constants shared by both ends of the tone transceiver host port.
// Assumes a single 250 MHz clock shared by host controller and device.
// Contract
// - Host performs software reset after power-up
// - Reset: read, 0,0, 8, 0 writes, read
// - Select high control/status, low transmit/receive
// - Read: rw high, or rd low wr high
// - Host writes 1101 to first control register
// - Second control register zero selects burst
// - Digit sent by writing code to transmit
// - Burst mode: tone burst then equal pause
// - Host waits interrupt or polls, reads status
// - Status bit1 means transmitter ready
// - Status bit2 means tone received
// - Both set: read receive, then write transmit
// - Ready no sooner than 100 ms after write
// - Extended burst doubles delay to 200 ms
// - Select bit redirects next control write once
// - Status read clears flags; irq follows them
// - Call progress mode extends burst timing
// - Interrupt low on receive or transmit ready
package dthri_pkg;
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned BURST_MS      = 100;
    localparam int unsigned EXT_BURST_MS  = 200;
    localparam longint unsigned BURST_CYCLES =
        (longint'(CLK_HZ) * BURST_MS) / 1000;
    localparam longint unsigned EXT_CYCLES =
        (longint'(CLK_HZ) * EXT_BURST_MS) / 1000;
    // Control register A bits
    localparam int CA_TONE  = 0;
    localparam int CA_CP    = 1;
    localparam int CA_IRQ   = 2;
    localparam int CA_SEL   = 3;
    // Control register B bits
    localparam int CB_BURST = 0;
    localparam int CB_RXPWR = 1;
    // Status bits
    localparam int ST_IRQ   = 0;
    localparam int ST_TXRDY = 1;
    localparam int ST_RXFUL = 2;
    localparam int ST_DSTEER = 3;
    localparam logic [3:0] NIB_ZERO   = 4'h0;
    localparam logic [3:0] CTL_RESET  = 4'h8;
    localparam logic [3:0] CTL_A_INIT = 4'hD;
    localparam logic [3:0] CTL_B_INIT = 4'h0;
endpackage

/* File: logic/dthri_if.sv */
// Parallel port between host controller and tone transceiver.
// Both ends run on the same clock; the bench drives nothing here.
`timescale 1ns/1ps
interface dthri_if;
    logic       registerSelectLine;
    logic       busStyleStrobe;   // 1: separate read/write strobes, 0: rw level
    logic       rwLevel;
    logic       rdStrobeN;
    logic       wrStrobeN;
    logic       csN;
    logic [3:0] dataToDev;
    logic [3:0] dataFromDev;
    logic       dataFromDevOe;
    logic       irqN;
    modport device (input registerSelectLine, busStyleStrobe, rwLevel, rdStrobeN,
                    wrStrobeN, csN, dataToDev, output dataFromDev, dataFromDevOe, irqN);
    modport host (output registerSelectLine, busStyleStrobe, rwLevel, rdStrobeN,
                  wrStrobeN, csN, dataToDev, input dataFromDev, dataFromDevOe, irqN);
endinterface

/* File: logic/dthri_burst_timer.sv */
// Burst-and-pause timer; pulses done when the full period has elapsed.
// Start restarts the count; assumes start is a single-cycle pulse.
`timescale 1ns/1ps
module dthri_burst_timer
    import dthri_pkg::*;
#(
    parameter longint unsigned NORMAL_CYCLES = BURST_CYCLES,
    parameter longint unsigned EXTEND_CYCLES = EXT_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // Control
    input  wire logic start,
    input  wire logic extended,
    // Result
    output logic      busy,
    output logic      done,
    output logic      firstHalf
);
    logic [31:0] count;
    logic [31:0] limit;

    // Extended mode doubles the whole burst plus pause
    assign limit = extended ? 32'(EXTEND_CYCLES) : 32'(NORMAL_CYCLES);

    // Tone for the first half of the period, pause of equal length after it
    assign firstHalf = busy && (count <= (limit >> 1));

    // Counter runs while a burst or pause is in progress
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count <= 32'h0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= 32'h1;
                busy  <= 1'b1;
            end else if (busy) begin
                if (count >= limit) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count + 32'h1;
                end
            end
        end
    end
endmodule

/* File: logic/dthri_device.sv */
// Device end: control, status, transmit and receive registers.
// Tone generation and detection are outside; received digits arrive on rxValid.
`timescale 1ns/1ps
module dthri_device
    import dthri_pkg::*;
#(
    parameter longint unsigned NORMAL_CYCLES = BURST_CYCLES,
    parameter longint unsigned EXTEND_CYCLES = EXT_CYCLES
) (
    // Clock and reset
    input  wire logic  sys_clk,
    input  wire logic  srst,
    // Host port
    dthri_if.device    port,
    // Detector side
    input  wire logic  rxValid,
    input  wire logic [3:0] rxCode,
    input  wire logic  rxAbsent,
    // Transmitter side
    output logic [3:0] txCode,
    output logic       txToneOn,
    output logic       tone_output_enable,
    output logic       call_progress_select,
    output logic       receiver_power_control,
    output logic [3:0] ctrlB
);
    logic [3:0] ctrlA;
    logic       second_control_select;
    logic [3:0] rxData;
    logic       flagTx;
    logic       flagRx;
    logic       steer;
    logic       rdReq;
    logic       wrReq;
    logic       rdD;
    logic       wrD;
    logic       rdPulse;
    logic       wrPulse;
    logic       timerBusy;
    logic       timerDone;
    logic       toneHalf;
    logic       burstMode;

    // Either bus style decodes to one read and one write level
    assign rdReq = !port.csN && (port.busStyleStrobe ?
                   (!port.rdStrobeN && port.wrStrobeN) : port.rwLevel);
    assign wrReq = !port.csN && (port.busStyleStrobe ?
                   (port.rdStrobeN && !port.wrStrobeN) : !port.rwLevel);

    // Act once per access, on the leading edge of the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdD <= 1'b0;
            wrD <= 1'b0;
        end else begin
            rdD <= rdReq;
            wrD <= wrReq;
        end
    end
    assign rdPulse = rdReq && !rdD;
    assign wrPulse = wrReq && !wrD;
    assign burstMode = !ctrlB[CB_BURST];

    // Control writes; the select bit steers only the next write
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrlA <= NIB_ZERO;
            ctrlB <= NIB_ZERO;
            second_control_select <= 1'b0;
        end else if (wrPulse && port.registerSelectLine) begin
            if (second_control_select) begin
                ctrlB <= port.dataToDev;
                second_control_select <= 1'b0;
            end else begin
                ctrlA <= port.dataToDev;
                second_control_select <= port.dataToDev[CA_SEL];
            end
        end
    end

    assign tone_output_enable     = ctrlA[CA_TONE];
    assign call_progress_select   = ctrlA[CA_CP];
    assign receiver_power_control = ctrlB[CB_RXPWR];

    // Transmit register is cleared while the transmitter is powered down
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txCode <= NIB_ZERO;
        end else if (!ctrlA[CA_TONE]) begin
            txCode <= NIB_ZERO;
        end else if (wrPulse && !port.registerSelectLine) begin
            txCode <= port.dataToDev;
        end
    end

    dthri_burst_timer #(
        .NORMAL_CYCLES (NORMAL_CYCLES),
        .EXTEND_CYCLES (EXTEND_CYCLES)
    ) u_timer (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .start    (wrPulse && !port.registerSelectLine && burstMode && ctrlA[CA_TONE]),
        .extended (ctrlA[CA_CP]),
        .busy      (timerBusy),
        .done      (timerDone),
        .firstHalf (toneHalf)
    );

    // In burst mode tone stays on for the first half, pause for the second; outside burst mode it stays on
    assign txToneOn = ctrlA[CA_TONE] && (burstMode ? toneHalf : 1'b1);

    // Transmit ready: hardware set wins over the clearing status read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flagTx <= 1'b0;
        end else if (timerDone && burstMode) begin
            flagTx <= 1'b1;
        end else if ((rdPulse && port.registerSelectLine) || !burstMode) begin
            flagTx <= 1'b0;
        end
    end

    // Receive full and its data; a tone landing on the clearing read still sets
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flagRx <= 1'b0;
            rxData <= NIB_ZERO;
        end else if (rxValid && !ctrlA[CA_CP]) begin
            flagRx <= 1'b1;
            rxData <= rxCode;
        end else if (rdPulse && port.registerSelectLine) begin
            flagRx <= 1'b0;
        end
    end

    // Delayed steering follows detector presence and absence
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            steer <= 1'b0;
        end else if (rxValid) begin
            steer <= 1'b0;
        end else if (rxAbsent) begin
            steer <= 1'b1;
        end
    end

    // Read data is captured as the read begins, before that read clears the flags
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port.dataFromDev <= NIB_ZERO;
        end else if (rdPulse) begin
            port.dataFromDev <= port.registerSelectLine ?
                {steer, flagRx, flagTx, flagTx | flagRx} : rxData;
        end
    end
    assign port.dataFromDevOe = rdReq && rdD;

    // Open-drain interrupt, low while enabled in DTMF mode and a flag stands
    assign port.irqN = !(ctrlA[CA_IRQ] && !ctrlA[CA_CP] && (flagTx || flagRx));
endmodule

/* File: tb/dthri_checker.sv */
// Checker for the host port: watches the wires between host and device.
// Assumes one clock; instantiated by the bench beside the interface.
`timescale 1ns/1ps
module dthri_checker
    import dthri_pkg::*;
#(
    parameter longint unsigned NORMAL_CYCLES = BURST_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // Port wires
    input  wire logic       registerSelectLine,
    input  wire logic       busStyleStrobe,
    input  wire logic       rwLevel,
    input  wire logic       rdStrobeN,
    input  wire logic       wrStrobeN,
    input  wire logic       csN,
    input  wire logic [3:0] dataToDev,
    input  wire logic [3:0] dataFromDev,
    input  wire logic       dataFromDevOe,
    input  wire logic       irqN
);
    localparam int TX_MAX = 400;  // Extended period plus slack for the host's polling
    logic        isRd;
    logic        isWr;
    logic        stRd;
    logic        txWr;
    logic        txPrev;
    logic        seenAcc;
    logic [31:0] txAge;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Decode the access kind in either strobe style
    assign isRd = busStyleStrobe ? (!rdStrobeN && wrStrobeN) : rwLevel;
    assign isWr = busStyleStrobe ? (!wrStrobeN && rdStrobeN) : !rwLevel;
    assign stRd = !csN && registerSelectLine && isRd;
    assign txWr = !csN && !registerSelectLine && isWr;

    // Previous transmit-write level, to find where a write begins
    always_ff @(posedge sys_clk) begin
        txPrev <= srst ? 1'h0 : txWr;
    end

    // Age since the last transmit write began; saturates so it never wraps to small
    always_ff @(posedge sys_clk) begin
        if (srst || (txWr && !txPrev)) begin
            txAge <= 32'h0;
        end else if (txAge != 32'hFFFFFFFF) begin
            txAge <= txAge + 32'h1;
        end
    end

    // First access after reset seen yet
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seenAcc <= 1'h0;
        end else if (!csN && (isRd || isWr)) begin
            seenAcc <= 1'h1;
        end
    end

    a_rw_exclusive: assert property (busStyleStrobe && !csN |-> rdStrobeN || wrStrobeN)
        else $error("read and write strobes low together");
    a_write_hold: assert property (
        busStyleStrobe && $fell(wrStrobeN) |->
        ##1 (!wrStrobeN && $stable(dataToDev) && $stable(registerSelectLine)) [*3])
        else $error("write released or changed too soon");
    a_first_status: assert property (
        !seenAcc && !csN && (isRd || isWr) |-> registerSelectLine && isRd)
        else $error("first access after reset is not a status read");
    a_oe_on_read: assert property (
        dataFromDevOe |-> (!csN && isRd) || $past(!csN && isRd))
        else $error("device drives data outside a read");
    a_irq_flag_or: assert property (
        dataFromDevOe && stRd && $past(stRd) |->
        dataFromDev[ST_IRQ] == (dataFromDev[ST_TXRDY] || dataFromDev[ST_RXFUL]))
        else $error("interrupt flag disagrees with ready and full flags");
    a_txrdy_early: assert property (
        dataFromDevOe && stRd && $past(stRd) && dataFromDev[ST_TXRDY] |->
        txAge >= NORMAL_CYCLES)
        else $error("transmitter ready before the burst period ended");
    a_tx_irq: assert property (txWr && !txPrev |-> ##[1:TX_MAX] !irqN)
        else $error("no interrupt after a transmit write");
    a_reset_quiet: assert property ($fell(srst) |-> irqN && !dataFromDevOe)
        else $error("interrupt or data drive active after reset");
endmodule

/* File: tb/tb.sv */
// Bench for the tone transceiver host port: host and device joined back to back.
// Assumes the design files compile first; runs both strobe styles in turn.
`timescale 1ns/1ps
module tb;
    import dthri_pkg::*;
    localparam int NC = 100;  // Shortened burst period keeps the run brief
    logic       sys_clk;
    logic       srst;
    logic       strobeStyle;
    logic       sendValid;
    logic       sendReady;
    logic       recvValid;
    logic       initDone;
    logic       rxValid;
    logic       rxAbsent;
    logic       txToneOn;
    logic       toneEn;
    logic       cpSel;
    logic       rxPwr;
    logic [3:0] sendCode;
    logic [3:0] recvCode;
    logic [3:0] rxCode;
    logic [3:0] txCode;
    logic [3:0] ctrlB;
    int         badCount = 0;
    int         nCompared = 0;
    int         cyc = 0;
    int         lastTake = 0;
    int         toneCnt = 0;

    dthri_if bus ();

    dthri_device #(.NORMAL_CYCLES(NC), .EXTEND_CYCLES(2 * NC)) u_dthri_device (
        .sys_clk(sys_clk), .srst(srst), .port(bus), .rxValid(rxValid), .rxCode(rxCode),
        .rxAbsent(rxAbsent), .txCode(txCode), .txToneOn(txToneOn),
        .tone_output_enable(toneEn), .call_progress_select(cpSel),
        .receiver_power_control(rxPwr), .ctrlB(ctrlB));
    dthri_host u_dthri_host (
        .sys_clk(sys_clk), .srst(srst), .port(bus), .strobeStyle(strobeStyle),
        .sendValid(sendValid), .sendCode(sendCode), .sendReady(sendReady),
        .recvValid(recvValid), .recvCode(recvCode), .initDone(initDone));
    dthri_checker #(.NORMAL_CYCLES(NC)) u_dthri_checker (
        .sys_clk(sys_clk), .srst(srst), .registerSelectLine(bus.registerSelectLine),
        .busStyleStrobe(bus.busStyleStrobe), .rwLevel(bus.rwLevel),
        .rdStrobeN(bus.rdStrobeN), .wrStrobeN(bus.wrStrobeN), .csN(bus.csN),
        .dataToDev(bus.dataToDev), .dataFromDev(bus.dataFromDev),
        .dataFromDevOe(bus.dataFromDevOe), .irqN(bus.irqN));

    // Clock and cycle count; tone cycles counted since the last digit was taken
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (txToneOn === 1'h1) begin
            toneCnt++;
        end
    end

    task automatic check(input logic ok, input string msg);
        nCompared++;
        if (ok !== 1'h1) begin
            badCount++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic conclude();
        $display("compared %0d, mismatched %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Offer a digit at a falling edge; held until the host shows ready
    task automatic send(input logic [3:0] code);
        int n;
        n = 0;
        sendCode = code;
        sendValid = 1'h1;
        while (sendReady !== 1'h1 && n < 400) begin
            n++;
            @(negedge sys_clk);
        end
        check(n < 400, "host never took a digit");
        if (lastTake > 0) begin
            check(cyc - lastTake >= NC, "ready too early");
            check(toneCnt >= NC / 2 - 2 && toneCnt <= NC / 2 + 2, "burst length");
        end
        @(negedge sys_clk);
        lastTake = cyc;
        toneCnt = 0;
        sendValid = 1'h0;
        n = 0;
        while (txCode !== code && n < 20) begin
            n++;
            @(negedge sys_clk);
        end
        check(txCode === code, "digit missing from transmit register");
    endtask

    // Detector reports one digit, then its absence; the host must hand it on
    task automatic recv(input logic [3:0] code);
        int n;
        n = 0;
        rxCode = code;
        rxValid = 1'h1;
        @(negedge sys_clk);
        rxValid = 1'h0;
        while (recvValid !== 1'h1 && n < 200) begin
            n++;
            @(negedge sys_clk);
        end
        check(recvValid === 1'h1 && recvCode === code, "received digit");
        rxAbsent = 1'h1;
        @(negedge sys_clk);
        rxAbsent = 1'h0;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        badCount++;
        $display("unexpected at %0t: run timed out", $time);
        conclude();
    end

    initial begin
        int n;
        srst = 1'h1;
        strobeStyle = 1'h1;
        sendValid = 1'h0;
        sendCode = 4'h0;
        rxValid = 1'h0;
        rxCode = 4'h0;
        rxAbsent = 1'h0;
        for (int s = 1; s >= 0; s--) begin
            @(negedge sys_clk);
            srst = 1'h1;
            strobeStyle = s[0];
            lastTake = 0;
            repeat (16) @(negedge sys_clk);
            srst = 1'h0;
            n = 0;
            while (initDone !== 1'h1 && n < 300) begin
                n++;
                @(negedge sys_clk);
            end
            check(initDone === 1'h1, "setup never finished");
            check(toneEn === 1'h1 && cpSel === 1'h0, "first control register");
            check(ctrlB === 4'h0 && rxPwr === 1'h0, "second control register");
            $display("test setup style %0d done", s);
            send(4'h7);
            recv(4'h9);
            send(4'h5);
            // Tone lands with transmit ready, so one status read shows both
            repeat (NC) @(negedge sys_clk);
            recv(4'h3);
            send(4'h7);
            $display("test traffic style %0d done", s);
        end
        conclude();
    end
endmodule
